// >>> acd_device.sv
// Converter end: main and modulator clock derivation plus per-channel decimation
//
// Behaviour
// - Oscillator off until clock select set
// - Oscillator divided by 1, 2 or 4
// - Modulator clock is half main clock
// - Host enters standby before source switch
// - Host enters standby before power change
// - Eight ratios 128 to 16384 selectable
// - One sample per ratio modulator clocks
// - Bitstream feeds sinc3 and sinc1 together
// - First conversions use fast sinc1 path
// - After two conversions stay on sinc3
// - Ratios up to 1024 use sinc3 only
// - Larger ratios: sinc3 at 1024 plus sinc1
// - Channel changes or resync restart settling
// - Unsettled samples reported; host latches them with settled bits low
// - Settling times per ratio in modulator clocks
// - Host trusts first ready after settling
// - Ready falls for each new sample
// - Two-bit field picks three power modes
// - Wait 300 modulator clocks before sampling
`timescale 1ns/100ps
`default_nettype none
module acd_device (
	input  wire logic                             clk,
	input  wire logic                             reset_n,
	acd_link_if.device                            link,
	input  wire logic [acd_pkg::ACD_CHANNELS-1:0] modulator_bit,
	output logic                                  oscillator_running,
	output logic                                  sampling_active,
	output logic                                  fast_path_selected
);
	localparam int NCH = acd_pkg::ACD_CHANNELS;

	// ----------------------------------------------------------------
	// Main and modulator clock ticks
	// ----------------------------------------------------------------
	logic       ext_s1_r;
	logic       ext_s2_r;
	logic       ext_s3_r;
	logic [1:0] div_cnt_r;
	logic       mod_phase_r;
	logic [1:0] div_last;
	logic       ext_rise;
	logic       int_tick;
	logic       main_tick;
	logic       mod_tick;

	// Reserved power code behaves as the slowest mode
	assign div_last = (link.power_mode_field == acd_pkg::ACD_FULL_RESOLUTION_MODE) ? 2'h0 :
	                  (link.power_mode_field == acd_pkg::ACD_REDUCED_POWER_MODE)   ? 2'h1 : 2'h3;
	assign ext_rise  = ext_s2_r & ~ext_s3_r;
	assign int_tick  = link.clock_select & (div_cnt_r == div_last);
	assign main_tick = link.clock_select ? int_tick : ext_rise;
	assign mod_tick  = main_tick & mod_phase_r;

	// Pin synchroniser and edge history for the external clock
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end
		else
		begin
			ext_s1_r <= link.external_clock_input;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end

	// Oscillator divider held idle while the oscillator is off
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			div_cnt_r <= 2'h0;
		else if (!link.clock_select || int_tick)
			div_cnt_r <= 2'h0;
		else
			div_cnt_r <= div_cnt_r + 2'h1;

	// Every other main tick is a modulator tick
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			mod_phase_r <= 1'b0;
		else if (main_tick)
			mod_phase_r <= ~mod_phase_r;

	// ----------------------------------------------------------------
	// Start-up wait and conversion phase
	// ----------------------------------------------------------------
	logic [8:0]  start_cnt_r;
	logic        started_r;
	logic [13:0] phase_r;
	logic [1:0]  conv_cnt_r;
	logic [2:0]  low_cnt_r;
	logic        ready_n_r;
	logic [3:0]  ratio_log2;
	logic [3:0]  sinc3_log2;
	logic [3:0]  casc_log2;
	logic [13:0] osr_last;
	logic [9:0]  sinc3_mask;
	logic        run;
	logic        restart_all;
	logic        sinc3_end;
	logic        out_end;
	logic        use_fast;

	assign ratio_log2  = acd_pkg::ACD_RATIO_LOG2_BASE + {1'b0, link.decimation_ratio_field};
	assign sinc3_log2  = (ratio_log2 > acd_pkg::ACD_SINC3_LOG2_MAX) ? acd_pkg::ACD_SINC3_LOG2_MAX
	                                                                 : ratio_log2;
	assign casc_log2   = ratio_log2 - sinc3_log2;
	assign osr_last    = 14'((15'h1 << ratio_log2) - 15'h1);
	assign sinc3_mask  = 10'((11'h1 << sinc3_log2) - 11'h1);
	assign run         = started_r & ~link.standby;
	assign restart_all = ~run | link.resync;
	assign sinc3_end   = mod_tick & run & ((phase_r[9:0] & sinc3_mask) == sinc3_mask);
	assign out_end     = mod_tick & ~restart_all & (phase_r == osr_last);
	assign use_fast    = conv_cnt_r < acd_pkg::ACD_CONV_FAST_COUNT;

	// Modulators start after the fixed wait in modulator clocks
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			start_cnt_r <= 9'h000;
			started_r   <= 1'b0;
		end
		else if (mod_tick && !started_r)
		begin
			start_cnt_r <= start_cnt_r + 9'h001;
			started_r   <= (start_cnt_r == acd_pkg::ACD_STARTUP_MOD_TICKS - 9'h001);
		end

	// Position within the output period, cleared on any global restart
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			phase_r <= 14'h0000;
		else if (restart_all || out_end)
			phase_r <= 14'h0000;
		else if (mod_tick)
			phase_r <= phase_r + 14'h0001;

	// Conversion count only rewinds on device reset
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			conv_cnt_r <= 2'h0;
		else if (out_end && use_fast)
			conv_cnt_r <= conv_cnt_r + 2'h1;

	// Ready goes low for a short fixed pulse on each new sample
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			ready_n_r <= 1'b1;
			low_cnt_r <= 3'h0;
		end
		else if (out_end)
		begin
			ready_n_r <= 1'b0;
			low_cnt_r <= acd_pkg::ACD_READY_LOW_CYCLES - 3'h1;
		end
		else if (low_cnt_r != 3'h0)
			low_cnt_r <= low_cnt_r - 3'h1;
		else
			ready_n_r <= 1'b1;

	// ----------------------------------------------------------------
	// Per-channel filters
	// ----------------------------------------------------------------
	logic [NCH-1:0][15:0] sample_r;

	generate
		for (genvar ch = 0; ch < NCH; ch++)
		begin : g_ch
			logic signed [31:0] i1_r, i2_r, i3_r;
			logic signed [31:0] d1_r, d2_r, d3_r;
			logic signed [19:0] casc_r;
			logic signed [15:0] fast_r;
			logic               en_q_r;
			logic [2:0]         gain_q_r;
			logic [1:0]         mux_q_r;
			logic signed [31:0] x;
			logic signed [31:0] c1, c2, c3;
			logic [15:0]        s3_norm;
			logic signed [35:0] casc_sum;
			logic signed [35:0] fast_sum;
			logic [15:0]        casc_out;
			logic [15:0]        fast_out;
			logic               ch_restart;

			assign ch_restart = restart_all | ~link.channel_enable[ch]
			                  | (link.channel_gain[ch] != gain_q_r)
			                  | (link.channel_mux[ch] != mux_q_r) | ~en_q_r;
			assign x        = modulator_bit[ch] ? 32'sh1 : -32'sh1;
			assign c1       = i3_r - d1_r;
			assign c2       = c1 - d2_r;
			assign c3       = c2 - d3_r;
			assign s3_norm  = acd_pkg::acd_saturate(36'(c3 >>> (3 * sinc3_log2 - 15)));
			assign casc_sum = 36'(casc_r) + 36'($signed(s3_norm));
			assign casc_out = acd_pkg::acd_saturate(casc_sum >>> casc_log2);
			assign fast_sum = 36'(fast_r) + 36'(x);
			assign fast_out = acd_pkg::acd_saturate(fast_sum <<< (15 - ratio_log2));

			// Remember settings to spot a change of gain or input selection
			always_ff @(posedge clk or negedge reset_n)
				if (!reset_n)
				begin
					en_q_r   <= 1'b0;
					gain_q_r <= 3'h0;
					mux_q_r  <= 2'h0;
				end
				else
				begin
					en_q_r   <= link.channel_enable[ch];
					gain_q_r <= link.channel_gain[ch];
					mux_q_r  <= link.channel_mux[ch];
				end

			// Integrators, combs, cascade and fast accumulators
			always_ff @(posedge clk or negedge reset_n)
				if (!reset_n)
				begin
					{i1_r, i2_r, i3_r} <= '0;
					{d1_r, d2_r, d3_r} <= '0;
					casc_r             <= '0;
					fast_r             <= '0;
				end
				else if (ch_restart)
				begin
					{i1_r, i2_r, i3_r} <= '0;
					{d1_r, d2_r, d3_r} <= '0;
					casc_r             <= '0;
					fast_r             <= '0;
				end
				else if (mod_tick && run)
				begin
					i1_r   <= i1_r + x;
					i2_r   <= i2_r + i1_r;
					i3_r   <= i3_r + i2_r;
					fast_r <= out_end ? 16'sh0000 : 16'(fast_sum);
					if (sinc3_end)
					begin
						d1_r   <= i3_r;
						d2_r   <= c1;
						d3_r   <= c2;
						casc_r <= out_end ? 20'sh00000 : 20'(casc_sum);
					end
				end

			// Output register picks the path for this conversion
			always_ff @(posedge clk or negedge reset_n)
				if (!reset_n)
					sample_r[ch] <= 16'h0000;
				else if (out_end)
					sample_r[ch] <= use_fast ? fast_out : casc_out;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic osc_run_r;
	logic fast_sel_r;

	// Status flops for the user side
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			osc_run_r  <= 1'b0;
			fast_sel_r <= 1'b1;
		end
		else
		begin
			osc_run_r  <= link.clock_select;
			fast_sel_r <= use_fast;
		end

	assign link.sample_ready_n = ready_n_r;
	assign link.sample_data    = sample_r;
	assign oscillator_running  = osc_run_r;
	assign sampling_active     = started_r;
	assign fast_path_selected  = fast_sel_r;
endmodule
`default_nettype wire

// >>> acd_host.sv
// Host end: Avalon-MM register front end that configures the converter and tracks settling
`timescale 1ns/100ps
`default_nettype none
module acd_host #(
	parameter logic [7:0] EXT_HALF_PERIOD = acd_pkg::ACD_EXT_HALF_PERIOD
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	acd_link_if.host         link,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);
	localparam int NCH = acd_pkg::ACD_CHANNELS;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic        wait_r;
	logic [31:0] rdata_r;
	logic [7:0]  ctrl_r;
	logic [15:0] chcfg_r;
	logic        resync_r;
	logic        req;
	logic        done;
	logic        wr_ctrl;
	logic        wr_chcfg;
	logic        rd_data;
	logic [31:0] bmask;
	logic [31:0] status_w;
	logic [31:0] rmux;
	logic [15:0] chcfg_nxt;
	logic        ctrl_lock;
	logic [7:0]  ctrl_nxt;

	assign req       = avs_read | avs_write;
	assign done      = req & ~wait_r;
	assign bmask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wr_ctrl   = done & avs_write & (avs_address == acd_pkg::ACD_REG_CONTROL);
	assign wr_chcfg  = done & avs_write & (avs_address == acd_pkg::ACD_REG_CHANNEL);
	assign rd_data   = done & avs_read & (avs_address == acd_pkg::ACD_REG_DATA);
	assign chcfg_nxt = (chcfg_r & ~bmask[15:0]) | (avs_writedata[15:0] & bmask[15:0]);

	// Source and power bits only move while standby is already set
	assign ctrl_lock = ~ctrl_r[acd_pkg::ACD_CTRL_STANDBY];
	assign ctrl_nxt  = ctrl_lock ? {avs_writedata[7:3], ctrl_r[2:0]} : avs_writedata[7:0];

	// Single wait state: answer one cycle after the request is seen
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			wait_r  <= ~(req & wait_r);
			rdata_r <= rmux;
		end

	// Control and channel registers; resync is a write pulse
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			ctrl_r   <= acd_pkg::ACD_CTRL_RESET;
			chcfg_r  <= 16'h0000;
			resync_r <= 1'b0;
		end
		else
		begin
			resync_r <= wr_ctrl & avs_byteenable[1] & avs_writedata[acd_pkg::ACD_CTRL_RESYNC];
			if (wr_ctrl && avs_byteenable[0])
				ctrl_r <= ctrl_nxt;
			if (wr_chcfg)
				chcfg_r <= chcfg_nxt;
		end

	// ----------------------------------------------------------------
	// External clock generator
	// ----------------------------------------------------------------
	logic [7:0] ext_cnt_r;
	logic       ext_clk_r;

	// Divided clock, held low while not enabled
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			ext_cnt_r <= 8'h00;
			ext_clk_r <= 1'b0;
		end
		else if (!ctrl_r[acd_pkg::ACD_CTRL_EXT_RUN])
		begin
			ext_cnt_r <= 8'h00;
			ext_clk_r <= 1'b0;
		end
		else if (ext_cnt_r == EXT_HALF_PERIOD - 8'h01)
		begin
			ext_cnt_r <= 8'h00;
			ext_clk_r <= ~ext_clk_r;
		end
		else
			ext_cnt_r <= ext_cnt_r + 8'h01;

	// ----------------------------------------------------------------
	// Sample capture and settling tracking
	// ----------------------------------------------------------------
	logic                 ready_q_r;
	logic                 new_r;
	logic [7:0]           count_r;
	logic [NCH-1:0][15:0] data_r;
	logic [NCH-1:0][15:0] elapsed_r;
	logic [NCH-1:0]       settled;
	logic                 ready_fall;
	logic [2:0]           osr_code;
	logic [16:0]          osr_mod;

	assign ready_fall = ready_q_r & ~link.sample_ready_n;
	assign osr_code   = ctrl_r[acd_pkg::ACD_CTRL_OSR_LSB +: 3];
	assign osr_mod    = 17'h00080 << osr_code;

	// Latch each sample; new flag set wins over the clearing read
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			ready_q_r <= 1'b1;
			new_r     <= 1'b0;
			count_r   <= 8'h00;
			data_r    <= '0;
		end
		else
		begin
			ready_q_r <= link.sample_ready_n;
			if (ready_fall)
			begin
				data_r  <= link.sample_data;
				count_r <= count_r + 8'h01;
			end
			new_r <= ready_fall | (new_r & ~rd_data);
		end

	generate
		for (genvar ch = 0; ch < NCH; ch++)
		begin : g_settle
			logic        restart;
			logic [16:0] sum;

			assign restart = wr_ctrl | resync_r | ctrl_r[acd_pkg::ACD_CTRL_STANDBY]
			               | (wr_chcfg & (chcfg_nxt[ch*8 +: 8] != chcfg_r[ch*8 +: 8]));
			assign sum          = {1'b0, elapsed_r[ch]} + osr_mod;
			assign settled[ch]  = elapsed_r[ch] >= acd_pkg::ACD_SETTLE_MOD[osr_code];

			// Modulator clocks elapsed since restart, counted per sample
			always_ff @(posedge clk or negedge reset_n)
				if (!reset_n)
					elapsed_r[ch] <= 16'h0000;
				else if (restart)
					elapsed_r[ch] <= 16'h0000;
				else if (ready_fall)
					elapsed_r[ch] <= sum[16] ? 16'hFFFF : sum[15:0];
		end
	endgenerate

	assign status_w = {16'h0000, count_r, 5'h00, new_r, settled};
	assign rmux = (avs_address == acd_pkg::ACD_REG_CONTROL) ? {24'h000000, ctrl_r} :
	              (avs_address == acd_pkg::ACD_REG_CHANNEL) ? {16'h0000, chcfg_r} :
	              (avs_address == acd_pkg::ACD_REG_STATUS)  ? status_w :
	              (avs_address == acd_pkg::ACD_REG_DATA)    ? {data_r[1], data_r[0]} : 32'h0000_0000;

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	generate
		for (genvar ch = 0; ch < NCH; ch++)
		begin : g_out
			assign link.channel_enable[ch] = chcfg_r[ch*8];
			assign link.channel_gain[ch]   = chcfg_r[ch*8+1 +: 3];
			assign link.channel_mux[ch]    = chcfg_r[ch*8+4 +: 2];
		end
	endgenerate
	assign link.clock_select           = ctrl_r[acd_pkg::ACD_CTRL_CLK_SEL];
	assign link.power_mode_field       = ctrl_r[acd_pkg::ACD_CTRL_PWR_LSB +: 2];
	assign link.decimation_ratio_field = osr_code;
	assign link.standby                = ctrl_r[acd_pkg::ACD_CTRL_STANDBY];
	assign link.resync                 = resync_r;
	assign link.external_clock_input   = ext_clk_r;
	assign avs_readdata                = rdata_r;
	assign avs_waitrequest             = wait_r;
endmodule
`default_nettype wire

// >>> acd_link_if.sv
// Link between the converter end and its controlling host end
`timescale 1ns/100ps
`default_nettype none
interface acd_link_if;
	logic                                                   clock_select;
	logic [1:0]                                             power_mode_field;
	logic [2:0]                                             decimation_ratio_field;
	logic                                                   standby;
	logic                                                   resync;
	logic [acd_pkg::ACD_CHANNELS-1:0]                       channel_enable;
	logic [acd_pkg::ACD_CHANNELS-1:0][2:0]                  channel_gain;
	logic [acd_pkg::ACD_CHANNELS-1:0][1:0]                  channel_mux;
	logic                                                   external_clock_input;
	logic                                                   sample_ready_n;
	logic [acd_pkg::ACD_CHANNELS-1:0][acd_pkg::ACD_SAMPLE_W-1:0] sample_data;

	modport device (
		input  clock_select, power_mode_field, decimation_ratio_field, standby, resync,
		input  channel_enable, channel_gain, channel_mux, external_clock_input,
		output sample_ready_n, sample_data
	);
	modport host (
		output clock_select, power_mode_field, decimation_ratio_field, standby, resync,
		output channel_enable, channel_gain, channel_mux, external_clock_input,
		input  sample_ready_n, sample_data
	);
endinterface
`default_nettype wire

// >>> acd_pkg.sv
// Shared constants and helpers for the converter clocking and decimation block
package acd_pkg;
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int ACD_CHANNELS    = 2;
	localparam int ACD_SAMPLE_W    = 16;
	localparam int ACD_CLK_HZ      = 50_000_000;

	// ----------------------------------------------------------------
	// Power modes and decimation codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ACD_FULL_RESOLUTION_MODE = 2'h0,
		ACD_REDUCED_POWER_MODE   = 2'h1,
		ACD_MINIMUM_POWER_MODE   = 2'h2
	} acd_power_mode_t;
	localparam logic [3:0] ACD_RATIO_LOG2_BASE  = 4'h7;  // Code 0 is 128
	localparam logic [3:0] ACD_SINC3_LOG2_MAX   = 4'hA;  // Sinc3 caps at 1024
	localparam logic [8:0] ACD_STARTUP_MOD_TICKS = 9'h12C; // 256 + 44
	localparam logic [2:0] ACD_READY_LOW_CYCLES = 3'h4;
	localparam logic [1:0] ACD_CONV_FAST_COUNT  = 2'h2;

	// Settling time in modulator clocks per decimation code
	localparam logic [15:0] ACD_SETTLE_MOD [8] = '{
		16'h01B0, 16'h0330, 16'h0630, 16'h0C30,
		16'h1830, 16'h2830, 16'h4830, 16'h8830
	};

	// ----------------------------------------------------------------
	// Host register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] ACD_REG_CONTROL = 4'h0;
	localparam logic [3:0] ACD_REG_CHANNEL = 4'h4;
	localparam logic [3:0] ACD_REG_STATUS  = 4'h8;
	localparam logic [3:0] ACD_REG_DATA    = 4'hC;
	localparam int ACD_CTRL_CLK_SEL   = 0;
	localparam int ACD_CTRL_PWR_LSB   = 1;
	localparam int ACD_CTRL_OSR_LSB   = 3;
	localparam int ACD_CTRL_STANDBY   = 6;
	localparam int ACD_CTRL_EXT_RUN   = 7;
	localparam int ACD_CTRL_RESYNC    = 8;
	localparam logic [7:0] ACD_CTRL_RESET = 8'h40;  // Standby, external source
	localparam logic [7:0] ACD_EXT_HALF_PERIOD = 8'h03;

	// Clamp a wide signed value to the sample width
	function automatic logic [15:0] acd_saturate(input logic signed [35:0] v);
		if (v > 36'sh0_0000_7FFF)
			return 16'h7FFF;
		else if (v < -36'sh0_0000_8000)
			return 16'h8000;
		else
			return v[15:0];
	endfunction
endpackage

// >>> acd_properties.sv
// Checker for the converter link timing
`timescale 1ns/100ps
`default_nettype none
module acd_properties (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        clock_select,
	input wire logic [1:0]  power_mode_field,
	input wire logic [2:0]  decimation_ratio_field,
	input wire logic        standby,
	input wire logic        resync,
	input wire logic        sample_ready_n,
	input wire logic [acd_pkg::ACD_CHANNELS-1:0][acd_pkg::ACD_SAMPLE_W-1:0] sample_data
);
	logic        ready_q_r;
	logic        steady_r;
	logic [17:0] gap_r;
	logic [7:0]  cfg_r;
	wire         fall_w = ready_q_r & ~sample_ready_n;
	wire  [7:0]  cfg_w = {clock_select, power_mode_field, decimation_ratio_field, standby, resync};
	wire  [17:0] period_w = 18'h00100 << ({1'b0, decimation_ratio_field} + {2'b00, power_mode_field});

	// Clocks since the last ready fall, and whether the setup stayed put
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			ready_q_r <= 1'b1;
			steady_r  <= 1'b0;
			gap_r     <= '0;
			cfg_r     <= '0;
		end
		else
		begin
			ready_q_r <= sample_ready_n;
			cfg_r     <= cfg_w;
			gap_r     <= fall_w ? '0 : gap_r + 18'h1;
			steady_r  <= (cfg_w == cfg_r) && (fall_w || steady_r);
		end

	// Link relations
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_low4; !sample_ready_n [*4]; endsequence
	property p_ready_width; $fell(sample_ready_n) |-> s_low4 ##1 sample_ready_n; endproperty
	a_ready_width: assert property (p_ready_width) else $error("ready width");
	property p_period; fall_w && steady_r && clock_select && !standby |-> gap_r == period_w - 18'h1; endproperty
	a_period: assert property (p_period) else $error("sample period");
	property p_data_hold; $changed(sample_data) |-> $fell(sample_ready_n); endproperty
	a_data_hold: assert property (p_data_hold) else $error("data moved");
	property p_standby_quiet; standby [*6] |-> sample_ready_n; endproperty
	a_standby_quiet: assert property (p_standby_quiet) else $error("sample in standby");
	property p_resync_pulse; resync |=> !resync; endproperty
	a_resync_pulse: assert property (p_resync_pulse) else $error("resync width");
	property p_resync_quiet; resync |-> ##4 sample_ready_n [*8]; endproperty
	a_resync_quiet: assert property (p_resync_quiet) else $error("sample after resync");
	property p_switch; $changed(clock_select) || $changed(power_mode_field) |-> $past(standby); endproperty
	a_switch: assert property (p_switch) else $error("switch outside standby");
	property p_reset_state; $rose(reset_n) |-> sample_ready_n && standby && !clock_select; endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state");
endmodule
`default_nettype wire

// >>> adc_clock_divider_decimation_filter_bench.sv
// Bench for host and converter ends joined by the link
`timescale 1ns/100ps
`default_nettype none
module adc_clock_divider_decimation_filter_bench;
	localparam logic [3:0] CTL = acd_pkg::ACD_REG_CONTROL;
	localparam logic [3:0] STS = acd_pkg::ACD_REG_STATUS;
	logic        clk;
	logic        reset_n;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [1:0]  modulator_bit;
	logic        oscillator_running;
	logic        sampling_active;
	logic        fast_path_selected;
	logic [31:0] q;
	int          n_fail;
	int          comparisons;
	int          c;
	int          pm;
	int          cd;

	acd_link_if acd_link_if_i ();
	acd_device acd_device_i (.clk(clk), .reset_n(reset_n), .link(acd_link_if_i), .modulator_bit(modulator_bit),
		.oscillator_running(oscillator_running), .sampling_active(sampling_active),
		.fast_path_selected(fast_path_selected));
	acd_host acd_host_i (.clk(clk), .reset_n(reset_n), .link(acd_link_if_i), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	acd_properties acd_properties_i (.clk(clk), .reset_n(reset_n), .clock_select(acd_link_if_i.clock_select),
		.power_mode_field(acd_link_if_i.power_mode_field), .standby(acd_link_if_i.standby),
		.decimation_ratio_field(acd_link_if_i.decimation_ratio_field), .resync(acd_link_if_i.resync),
		.sample_ready_n(acd_link_if_i.sample_ready_n), .sample_data(acd_link_if_i.sample_data));

	// Clock generator
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic final_report;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 50)
		begin
			n_fail++;
			final_report();
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	// Clocks until the next ready fall
	task automatic wait_fall(output int n);
		n = 0;
		while (acd_link_if_i.sample_ready_n !== 1'b1 && n < 70000)
		begin
			@(posedge clk);
			n++;
		end
		while (acd_link_if_i.sample_ready_n !== 1'b0 && n < 70000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 70000)
		begin
			n_fail++;
			final_report();
		end
	endtask

	// Main sequence
	initial
	begin
		n_fail = 0;
		comparisons = 0;
		reset_n = 1'b0;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		modulator_bit = 2'h1;  // Channel 0 steady +1, channel 1 steady -1
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, CTL, 32'h0, q);
		check(q, 32'h40);
		check({31'h0, oscillator_running}, 32'h0);
		bus(1'b1, 4'h2, 32'hFFFF_FFFF, q);
		bus(1'b0, 4'h2, 32'h0, q);
		check(q, 32'h0);
		bus(1'b1, acd_pkg::ACD_REG_CHANNEL, 32'h0101, q);
		bus(1'b1, CTL, 32'h41, q);
		bus(1'b1, CTL, 32'h01, q);
		check({31'h0, oscillator_running}, 32'h1);
		check({31'h0, sampling_active}, 32'h0);
		wait_fall(c);
		check({31'h0, sampling_active}, 32'h1);
		check({31'h0, fast_path_selected}, 32'h1);
		wait_fall(c);
		check(c, 32'd256);
		repeat (8) @(posedge clk);
		check({31'h0, fast_path_selected}, 32'h0);
		bus(1'b0, STS, 32'h0, q);
		check({16'h0, q[15:8], 5'h0, q[2:0]}, 32'h0204);
		bus(1'b0, acd_pkg::ACD_REG_DATA, 32'h0, q);
		check(q, 32'h8000_7FFF);
		bus(1'b0, STS, 32'h0, q);
		check({29'h0, q[2:0]}, 32'h0);
		wait_fall(c);
		wait_fall(c);
		repeat (8) @(posedge clk);
		bus(1'b0, STS, 32'h0, q);
		check({30'h0, q[1:0]}, 32'h3);
		bus(1'b0, acd_pkg::ACD_REG_DATA, 32'h0, q);
		check(q, 32'h8000_7FFF);
		bus(1'b1, CTL, 32'h101, q);
		bus(1'b0, STS, 32'h0, q);
		check({30'h0, q[1:0]}, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			pm = (i > 5) ? i - 5 : 0;
			cd = (i > 5) ? i - 6 : i;
			bus(1'b1, CTL, 32'h41 | (pm << 1) | (cd << 3), q);
			repeat (8) @(posedge clk);
			bus(1'b1, CTL, 32'h01 | (pm << 1) | (cd << 3), q);
			wait_fall(c);
			wait_fall(c);
			check(c, 32'd256 << (pm + cd));
		end
		// External clock source through standby, then a second reset
		bus(1'b1, CTL, 32'hC0, q);
		bus(1'b1, CTL, 32'h80, q);
		wait_fall(c);
		wait_fall(c);
		check(c, 512 * acd_pkg::ACD_EXT_HALF_PERIOD);
		check({31'h0, oscillator_running}, 32'h0);
		reset_n <= 1'b0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		check({30'h0, sampling_active, fast_path_selected}, 32'h1);
		final_report();
	end
endmodule
`default_nettype wire
